// ---- track_arm_regs.vh ----
`ifndef TRACK_ARM_REGS_VH
`define TRACK_ARM_REGS_VH
// Register byte offsets
`define OFS_MONITOR 8'h00
`define OFS_ASSIGN 8'h04
`define OFS_ARM 8'h08
`define OFS_TRANSPORT 8'h0C
`define OFS_STATUS 8'h10
`define OFS_LOCATE 8'h14
`define OFS_LAST_TAKE 8'h18
`define OFS_METER_IN 8'h1C
`define OFS_METER_BUS 8'h20
`define OFS_METER_TRK 8'h24
// Monitor register fields
`define MON_DUAL_MONO 0
`define MON_SRC_A 1
`define MON_SRC_B 2
// Reset values
`define ASSIGN_RESET 4'hA
`define MONITOR_RESET 3'h6
// Arm states
`define ARM_OFF 2'h0
`define ARM_STANDBY 2'h1
`define ARM_RECORD 2'h2
// Overload hold time in ms and cycles at 20 MHz
`define OVL_HOLD_MS 500
`define CLK_HZ 20000000
`define OVL_HOLD_CYC ((`OVL_HOLD_MS * (`CLK_HZ / 1000)))
// Blink half period in cycles
`define BLINK_CYC 5000000
// Audio sample width and overload threshold
`define SMP_W 16
`define OVL_LEVEL 16'h7800
`endif

// ---- pin_sync.v ----
`timescale 1ns/1ps
`default_nettype none
// Two-stage synchroniser for one pin
module pin_sync (
  input wire CLK,
  input wire NRST,
  input wire d,
  output reg q
);
  reg meta;
  // First stage only feeds the second
  always @(posedge CLK) begin
    if (!NRST) begin
      meta <= 1'b0;
      q <= 1'b0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
`default_nettype wire

// ---- level_meter.v ----
`timescale 1ns/1ps
`default_nettype none
`include "track_arm_regs.vh"
// Absolute-level meter with overload hold
module level_meter #(
  parameter [31:0] HOLD = 32'd10000000
) (
  input wire CLK,
  input wire NRST,
  input wire signed [15:0] smp,
  output reg [15:0] level,
  output reg over
);
  reg [31:0] hold_cnt;
  wire [15:0] mag;
  assign mag = smp[15] ? (~smp + 16'h0001) : smp;
  // Overload marker held, then clears itself
  always @(posedge CLK) begin
    if (!NRST) begin
      level <= 16'h0000;
      over <= 1'b0;
      hold_cnt <= 32'h00000000;
    end else begin
      level <= mag;
      if (mag >= `OVL_LEVEL) begin
        over <= 1'b1;
        hold_cnt <= HOLD;
      end else if (hold_cnt != 32'h00000000) begin
        hold_cnt <= hold_cnt - 32'h00000001;
      end else begin
        over <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ---- track_arm_monitor_router.v ----
`timescale 1ns/1ps
`default_nettype none
`include "track_arm_regs.vh"
module track_arm_monitor_router #(
  parameter [31:0] OVL_HOLD = `OVL_HOLD_CYC,
  parameter [31:0] BLINK = `BLINK_CYC
) (
  // Clock and reset
  input wire CLK,
  input wire NRST,
  // Wishbone slave
  input wire WB_CYC,
  input wire WB_STB,
  input wire WB_WE,
  input wire [7:0] WB_ADR,
  input wire [3:0] WB_SEL,
  input wire [31:0] WB_DAT_I,
  output reg [31:0] WB_DAT_O,
  output reg WB_ACK,
  // Front-panel keys, raw pins
  input wire [3:0] KEY_ARM,
  input wire KEY_RECORD,
  input wire KEY_PLAY,
  input wire KEY_STOP,
  input wire KEY_FF,
  input wire KEY_REW,
  // Audio samples, one per clock
  input wire signed [15:0] IN_A,
  input wire signed [15:0] IN_B,
  input wire signed [15:0] TRACK_MIX_L,
  input wire signed [15:0] TRACK_MIX_R,
  input wire [63:0] TRACK_PLAY,
  // Monitor outputs
  output reg signed [15:0] OUT_L,
  output reg signed [15:0] OUT_R,
  // Indicators
  output reg [3:0] ARM_LED,
  output reg RECORD_LED,
  output wire OVERLOAD_FLAG_A,
  output wire OVERLOAD_FLAG_B,
  // Transport
  output reg RECORDING,
  output reg PLAYING,
  output reg LOCATE_PULSE,
  output reg [31:0] LOCATE_POS,
  input wire [31:0] POSITION
);
  // Transport states
  localparam [2:0] ST_STOP = 3'b001;
  localparam [2:0] ST_PLAY = 3'b010;
  localparam [2:0] ST_REC = 3'b100;

  reg [2:0] state;
  reg [2:0] monitor;
  reg [3:0] assign_b;
  reg [7:0] arm;
  reg [1:0] age [0:3];
  reg [31:0] last_take;
  reg [31:0] blink_cnt;
  reg blink;
  reg [9:0] key_prev;
  reg signed [15:0] trk_meter_smp [0:3];
  integer i;

  // Key synchronisers
  wire [9:0] key_raw;
  wire [9:0] key_s;
  wire [9:0] key_rise;
  assign key_raw = {1'b0, KEY_REW, KEY_FF, KEY_STOP, KEY_PLAY, KEY_RECORD, KEY_ARM};
  genvar g;
  generate
    for (g = 0; g < 10; g = g + 1) begin : ks
      pin_sync u_sync (
        .CLK(CLK),
        .NRST(NRST),
        .d(key_raw[g]),
        .q(key_s[g])
      );
    end
  endgenerate
  assign key_rise = key_s & ~key_prev;

  // Count of tracks in standby or record
  wire [2:0] armed_cnt;
  assign armed_cnt = {2'b00, arm[1:0] != `ARM_OFF} + {2'b00, arm[3:2] != `ARM_OFF}
    + {2'b00, arm[5:4] != `ARM_OFF} + {2'b00, arm[7:6] != `ARM_OFF};

  // Oldest armed track: the armed track whose age is 1
  reg [1:0] oldest;
  always @* begin
    oldest = 2'd0;
    for (i = 0; i < 4; i = i + 1) begin
      if (arm[2*i +: 2] != `ARM_OFF && age[i] == 2'd1) begin
        oldest = i[1:0];
      end
    end
  end

  // Bus write decode
  wire wb_wr;
  assign wb_wr = WB_CYC && WB_STB && WB_WE && !WB_ACK && WB_SEL[0];

  // Arm state, arming order and transport
  always @(posedge CLK) begin
    if (!NRST) begin
      state <= ST_STOP;
      arm <= 8'h00;
      for (i = 0; i < 4; i = i + 1) begin
        age[i] <= 2'd0;
      end
      last_take <= 32'h00000000;
      LOCATE_PULSE <= 1'b0;
      LOCATE_POS <= 32'h00000000;
      key_prev <= 10'h000;
    end else begin
      key_prev <= key_s;
      LOCATE_PULSE <= 1'b0;
      // Arm keys only act while not recording; every key rising in a cycle arms its own track
      if (state != ST_REC) begin
        for (i = 3; i >= 0; i = i - 1) begin
          if (key_rise[i] && arm[2*i +: 2] == `ARM_OFF) begin
            arm[2*i +: 2] <= `ARM_STANDBY;
            age[i] <= 2'd2;
            if (armed_cnt == 3'd2) begin
              arm[2*oldest +: 2] <= `ARM_OFF;
              age[oldest] <= 2'd0;
            end
          end
        end
        // Newer arm ages the other standby track
        if (key_rise[3:0] != 4'h0) begin
          for (i = 0; i < 4; i = i + 1) begin
            if (age[i] == 2'd2 && !key_rise[i]) begin
              age[i] <= 2'd1;
            end
          end
        end
      end
      case (state)
        ST_STOP, ST_PLAY: begin
          if (key_s[4] && key_rise[5]) begin
            state <= ST_REC;
            last_take <= POSITION;
            for (i = 0; i < 4; i = i + 1) begin
              if (arm[2*i +: 2] == `ARM_STANDBY) begin
                arm[2*i +: 2] <= `ARM_RECORD;
              end
            end
          end else if (key_rise[5]) begin
            state <= ST_PLAY;
          end else if (key_rise[6]) begin
            state <= ST_STOP;
          end
          // Locate keys pressed with stop held
          if (key_s[6] && key_rise[7]) begin
            LOCATE_PULSE <= 1'b1;
            LOCATE_POS <= last_take;
          end else if (key_s[6] && key_rise[8]) begin
            LOCATE_PULSE <= 1'b1;
            LOCATE_POS <= 32'h00000000;
          end
        end
        ST_REC: begin
          if (key_rise[6]) begin
            state <= ST_STOP;
            for (i = 0; i < 4; i = i + 1) begin
              if (arm[2*i +: 2] == `ARM_RECORD) begin
                arm[2*i +: 2] <= `ARM_STANDBY;
              end
            end
          end
        end
        default: state <= ST_STOP;
      endcase
      // Software disarm clears arms while stopped
      if (wb_wr && WB_ADR == `OFS_ARM && state == ST_STOP && WB_DAT_I[0]) begin
        arm <= 8'h00;
        for (i = 0; i < 4; i = i + 1) begin
          age[i] <= 2'd0;
        end
      end
    end
  end

  // Software settings: monitor mode, sources, track assignment
  always @(posedge CLK) begin
    if (!NRST) begin
      monitor <= `MONITOR_RESET;
      assign_b <= `ASSIGN_RESET;
    end else if (wb_wr) begin
      if (WB_ADR == `OFS_MONITOR) begin
        monitor <= WB_DAT_I[2:0];
      end
      if (WB_ADR == `OFS_ASSIGN) begin
        assign_b <= WB_DAT_I[3:0];
      end
    end
  end

  // Indicator blink timer
  always @(posedge CLK) begin
    if (!NRST) begin
      blink_cnt <= 32'h00000000;
      blink <= 1'b0;
    end else if (blink_cnt >= BLINK - 32'h00000001) begin
      blink_cnt <= 32'h00000000;
      blink <= ~blink;
    end else begin
      blink_cnt <= blink_cnt + 32'h00000001;
    end
  end

  // Mic input passed by its monitor source bit or by arm of any track fed by it
  reg pass_a;
  reg pass_b;
  always @* begin
    pass_a = monitor[`MON_SRC_A];
    pass_b = monitor[`MON_SRC_B];
    for (i = 0; i < 4; i = i + 1) begin
      if (arm[2*i +: 2] != `ARM_OFF) begin
        if (assign_b[i]) begin
          pass_b = 1'b1;
        end else begin
          pass_a = 1'b1;
        end
      end
    end
  end

  // Monitor mix, saturating; two extra bits guard the sum
  wire signed [15:0] mon_a;
  wire signed [15:0] mon_b;
  wire signed [17:0] mono;
  reg signed [17:0] sum_l;
  reg signed [17:0] sum_r;
  assign mon_a = pass_a ? IN_A : 16'sh0000;
  assign mon_b = pass_b ? IN_B : 16'sh0000;
  assign mono = {{2{mon_a[15]}}, mon_a} + {{2{mon_b[15]}}, mon_b};
  always @* begin
    if (monitor[`MON_DUAL_MONO]) begin
      sum_l = mono;
      sum_r = mono;
    end else begin
      sum_l = {{2{mon_a[15]}}, mon_a};
      sum_r = {{2{mon_b[15]}}, mon_b};
    end
    if (state != ST_STOP) begin
      sum_l = sum_l + {{2{TRACK_MIX_L[15]}}, TRACK_MIX_L};
      sum_r = sum_r + {{2{TRACK_MIX_R[15]}}, TRACK_MIX_R};
    end
  end

  function [15:0] sat;
    input [17:0] v;
    begin
      if (v[17] == 1'b0 && v[16:15] != 2'b00) begin
        sat = 16'h7FFF;
      end else if (v[17] == 1'b1 && v[16:15] != 2'b11) begin
        sat = 16'h8000;
      end else begin
        sat = v[15:0];
      end
    end
  endfunction

  // Registered outputs and indicators
  always @(posedge CLK) begin
    if (!NRST) begin
      OUT_L <= 16'sh0000;
      OUT_R <= 16'sh0000;
      ARM_LED <= 4'h0;
      RECORD_LED <= 1'b0;
      RECORDING <= 1'b0;
      PLAYING <= 1'b0;
    end else begin
      OUT_L <= sat(sum_l);
      OUT_R <= sat(sum_r);
      RECORD_LED <= (state == ST_REC);
      RECORDING <= (state == ST_REC);
      PLAYING <= (state != ST_STOP);
      for (i = 0; i < 4; i = i + 1) begin
        ARM_LED[i] <= (arm[2*i +: 2] == `ARM_RECORD)
          || (arm[2*i +: 2] == `ARM_STANDBY && blink);
      end
    end
  end

  // Track meter source selection
  always @* begin
    for (i = 0; i < 4; i = i + 1) begin
      if (arm[2*i +: 2] == `ARM_RECORD
          || (arm[2*i +: 2] == `ARM_STANDBY && state == ST_STOP)) begin
        trk_meter_smp[i] = assign_b[i] ? IN_B : IN_A;
      end else begin
        trk_meter_smp[i] = TRACK_PLAY[16*i +: 16];
      end
    end
  end

  // Meters: inputs, bus pair, tracks
  wire [15:0] lvl [0:7];
  wire [7:0] ovl;
  wire signed [15:0] msrc [0:7];
  assign msrc[0] = IN_A;
  assign msrc[1] = IN_B;
  assign msrc[2] = OUT_L;
  assign msrc[3] = OUT_R;
  generate
    for (g = 0; g < 4; g = g + 1) begin : tm
      assign msrc[4+g] = trk_meter_smp[g];
    end
    for (g = 0; g < 8; g = g + 1) begin : mt
      level_meter #(.HOLD(OVL_HOLD)) u_meter (
        .CLK(CLK),
        .NRST(NRST),
        .smp(msrc[g]),
        .level(lvl[g]),
        .over(ovl[g])
      );
    end
  endgenerate
  assign OVERLOAD_FLAG_A = ovl[0];
  assign OVERLOAD_FLAG_B = ovl[1];

  // Wishbone read mux and single-cycle ack
  always @(posedge CLK) begin
    if (!NRST) begin
      WB_ACK <= 1'b0;
      WB_DAT_O <= 32'h00000000;
    end else begin
      WB_ACK <= WB_CYC && WB_STB && !WB_ACK;
      case (WB_ADR)
        `OFS_MONITOR: WB_DAT_O <= {29'h0, monitor};
        `OFS_ASSIGN: WB_DAT_O <= {28'h0, assign_b};
        `OFS_ARM: WB_DAT_O <= {24'h0, arm};
        `OFS_TRANSPORT: WB_DAT_O <= {29'h0, state};
        `OFS_STATUS: WB_DAT_O <= {24'h0, ovl};
        `OFS_LOCATE: WB_DAT_O <= LOCATE_POS;
        `OFS_LAST_TAKE: WB_DAT_O <= last_take;
        `OFS_METER_IN: WB_DAT_O <= {lvl[1], lvl[0]};
        `OFS_METER_BUS: WB_DAT_O <= {lvl[3], lvl[2]};
        `OFS_METER_TRK: WB_DAT_O <= {lvl[5][15:8], lvl[4][15:8], lvl[7][15:8], lvl[6][15:8]};
        default: WB_DAT_O <= 32'h00000000;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- track_arm_monitor_router_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module track_arm_monitor_router_sva (
  // Clock, reset and bus handshake
  input wire CLK,
  input wire NRST,
  input wire WB_CYC,
  input wire WB_STB,
  input wire WB_ACK,
  // Keys, transport and indicators
  input wire KEY_STOP,
  input wire RECORDING,
  input wire PLAYING,
  input wire RECORD_LED,
  input wire LOCATE_PULSE,
  input wire [3:0] ARM_LED,
  input wire OVERLOAD_FLAG_A
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  // Open request and a stop press landing during a take
  sequence bus_req;
    WB_CYC && WB_STB && !WB_ACK;
  endsequence
  sequence stop_in_take;
    $rose(KEY_STOP) ##0 RECORDING;
  endsequence
  chk_ack_next: assert property (bus_req |=> WB_ACK) else $error("ack late");
  chk_ack_pulse: assert property (WB_ACK |=> !WB_ACK) else $error("ack stuck");
  chk_rec_led: assert property (RECORDING |-> RECORD_LED && PLAYING)
    else $error("record lamp off");
  chk_rec_steady: assert property (RECORDING && $past(RECORDING, 2) |-> $stable(ARM_LED))
    else $error("arm lamp blinks in take");
  chk_two_armed: assert property ($countones(ARM_LED) <= 2) else $error("over two armed");
  chk_stop_ends: assert property (stop_in_take |-> ##[1:8] !RECORDING)
    else $error("take not ended");
  chk_locate_one: assert property (LOCATE_PULSE |=> !LOCATE_PULSE)
    else $error("locate pulse long");
  chk_ovl_hold: assert property ($rose(OVERLOAD_FLAG_A) |-> OVERLOAD_FLAG_A [*8])
    else $error("overload not held");
  // Reset is the one place the default disable must not apply
  chk_reset_clear: assert property (disable iff (1'h0) !NRST |=>
    !WB_ACK && ARM_LED == 4'h0 && !RECORDING && !LOCATE_PULSE)
    else $error("reset left state");
endmodule
`default_nettype wire

// ---- front_panel_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Front-panel keys as a player works them
module front_panel_model (
  // Clock and wanted keys
  input wire CLK,
  input wire [8:0] hold,
  // Key pins
  output logic [3:0] KEY_ARM,
  output logic KEY_RECORD,
  output logic KEY_PLAY,
  output logic KEY_STOP,
  output logic KEY_FF,
  output logic KEY_REW
);
  initial {KEY_ARM, KEY_RECORD, KEY_PLAY, KEY_STOP, KEY_FF, KEY_REW} = 9'h000;
  // Modifier goes down a cycle first, so a combo never starts bare
  always @(posedge CLK) begin
    KEY_ARM <= hold[3:0];
    KEY_RECORD <= hold[4];
    KEY_STOP <= hold[6];
    KEY_PLAY <= hold[5] & (~hold[4] | KEY_RECORD);
    KEY_FF <= hold[7] & (~hold[6] | KEY_STOP);
    KEY_REW <= hold[8] & (~hold[6] | KEY_STOP);
  end
endmodule
`default_nettype wire

// ---- track_arm_monitor_router_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
bind track_arm_monitor_router track_arm_monitor_router_sva i_chk (.CLK, .NRST, .WB_CYC,
  .WB_STB, .WB_ACK, .KEY_STOP, .RECORDING, .PLAYING, .RECORD_LED, .LOCATE_PULSE, .ARM_LED,
  .OVERLOAD_FLAG_A);
module track_arm_monitor_router_tb_top;
  typedef struct packed {logic [2:0] mon; logic [15:0] a, b, l, r;} row_t;
  logic CLK = 1'h0;
  logic NRST = 1'h0;
  logic cyc = 1'h0, we = 1'h0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rd, pos = 32'h0, npulse = 32'h0;
  logic [15:0] in_a = 16'h0, in_b = 16'h0;
  logic [63:0] tplay = 64'h4000_3000_2000_1000;
  logic [8:0] hold = 9'h000;
  logic [1:0] seen;
  wire [31:0] dat_o, loc_pos;
  wire [15:0] out_l, out_r;
  wire [3:0] arm_led, key_arm;
  wire ack, rec_led, ovl_a, recording, locate, k_rec, k_play, k_stop, k_ff, k_rew;
  int error_cnt = 0;
  int compares = 0;
  // Monitor mode, inputs, expected left and right
  row_t rows [6] = '{'{3'h6, 16'h04D2, 16'hFF9C, 16'h04D2, 16'hFF9C},
    '{3'h7, 16'h03E8, 16'h07D0, 16'h0BB8, 16'h0BB8}, '{3'h7, 16'h7000, 16'h7000, 16'h7FFF, 16'h7FFF},
    '{3'h7, 16'h9000, 16'h9000, 16'h8000, 16'h8000}, '{3'h4, 16'h1111, 16'h2222, 16'h0000, 16'h2222},
    '{3'h2, 16'h1111, 16'h2222, 16'h1111, 16'h0000}};
  always #25 CLK = ~CLK;
  // Short hold and blink so the run stays brief
  track_arm_monitor_router #(.OVL_HOLD(32'h14), .BLINK(32'h4)) i_dut (.CLK(CLK), .NRST(NRST),
    .WB_CYC(cyc), .WB_STB(cyc), .WB_WE(we), .WB_ADR(adr), .WB_SEL(4'hF), .WB_DAT_I(wdat),
    .WB_DAT_O(dat_o), .WB_ACK(ack), .KEY_ARM(key_arm), .KEY_RECORD(k_rec), .KEY_PLAY(k_play),
    .KEY_STOP(k_stop), .KEY_FF(k_ff), .KEY_REW(k_rew), .IN_A(in_a), .IN_B(in_b),
    .TRACK_MIX_L(16'h0010), .TRACK_MIX_R(16'h0020), .TRACK_PLAY(tplay), .OUT_L(out_l),
    .OUT_R(out_r), .ARM_LED(arm_led), .RECORD_LED(rec_led), .OVERLOAD_FLAG_A(ovl_a),
    .OVERLOAD_FLAG_B(), .RECORDING(recording), .PLAYING(), .LOCATE_PULSE(locate),
    .LOCATE_POS(loc_pos), .POSITION(pos));
  front_panel_model i_panel (.CLK(CLK), .hold(hold), .KEY_ARM(key_arm), .KEY_RECORD(k_rec),
    .KEY_PLAY(k_play), .KEY_STOP(k_stop), .KEY_FF(k_ff), .KEY_REW(k_rew));
  // Count locate pulses
  always @(posedge CLK) if (locate === 1'h1) npulse <= npulse + 32'h1;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Request held until the rising edge that samples ack; data taken and request dropped there
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    cyc <= 1'h1; we <= w; adr <= a; wdat <= d;
    do @(posedge CLK); while (ack !== 1'h1);
    rd = dat_o;
    cyc <= 1'h0; we <= 1'h0;
  endtask
  // Long enough for the key synchronisers
  task automatic press(input logic [8:0] m);
    @(posedge CLK) hold <= m;
    repeat (8) @(posedge CLK);
    hold <= 9'h000;
    repeat (8) @(posedge CLK);
  endtask
  task automatic print_verdict();
    if (error_cnt == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    #(50 * 20000);
    error_cnt++;
    print_verdict();
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge CLK);
    NRST <= 1'h1;
    wb(1'h0, 8'h04, 32'h0); chk(rd, 32'hA);
    wb(1'h0, 8'h00, 32'h0); chk(rd, 32'h6);
    wb(1'h0, 8'hFC, 32'h0); chk(rd, 32'h0);
    foreach (rows[i]) begin
      wb(1'h1, 8'h00, {29'h0, rows[i].mon});
      @(posedge CLK) {in_a, in_b} <= {rows[i].a, rows[i].b};
      repeat (3) @(negedge CLK);
      chk({out_l, out_r}, {rows[i].l, rows[i].r});
    end
    press(9'h001); press(9'h002); press(9'h004);
    wb(1'h0, 8'h08, 32'h0); chk(rd, 32'h14);
    chk({out_l, out_r}, 32'h11112222);
    seen = 2'h0;
    repeat (10) @(negedge CLK) seen = seen | (arm_led[1] ? 2'h2 : 2'h1);
    chk({arm_led[0], seen}, 3'h3);
    @(posedge CLK) pos <= 32'h1234;
    press(9'h030);
    wb(1'h0, 8'h08, 32'h0); chk(rd, 32'h28);
    chk({rec_led, recording, arm_led}, 6'h36);
    chk({out_l, out_r}, 32'h11212242);
    press(9'h040);
    wb(1'h0, 8'h08, 32'h0); chk({recording, rd}, 33'h14);
    @(posedge CLK) pos <= 32'h9999;
    press(9'h0C0); chk(loc_pos, 32'h1234);
    press(9'h140); chk({npulse, loc_pos}, 64'h2_0000_0000);
    @(posedge CLK) in_a <= 16'h7800;
    for (int k = 0; k < 10 && ovl_a !== 1'h1; k++) @(negedge CLK);
    chk(ovl_a, 1'h1);
    @(posedge CLK) in_a <= 16'h0;
    repeat (40) @(negedge CLK);
    chk(ovl_a, 1'h0);
    @(posedge CLK) NRST <= 1'h0;
    repeat (3) @(posedge CLK);
    NRST <= 1'h1;
    wb(1'h0, 8'h08, 32'h0); chk({arm_led, rd}, 36'h0);
    wb(1'h0, 8'h24, 32'h0); chk(rd, 32'h20104030);
    print_verdict();
  end
endmodule
`default_nettype wire
